// file: tcpe_pkg.sv
// Constants shared by the Type-C attach PHY enable logic.
// Assumes a single clock domain; nothing here holds a process.
package tcpe_pkg;

  // ---------------------------------------------------------------------------
  // Port counts
  // ---------------------------------------------------------------------------
  localparam int unsigned TCPE_NUM_ATTACH = 3;
  localparam int unsigned TCPE_NUM_ORIENT = 2;

  // ---------------------------------------------------------------------------
  // Pin level meanings
  // ---------------------------------------------------------------------------
  localparam logic TCPE_POL_NORMAL   = 1'h0; // Polarity select low: a 1 means attach.
  localparam logic TCPE_POL_INVERTED = 1'h1; // Polarity select high: a 0 means attach.
  localparam logic TCPE_ORIENT_B_RAW = 1'h1; // Raw orientation level that picks PHY B at normal polarity.
  localparam logic TCPE_RST_ASSERTED = 1'h0; // Level of the synchronised reset while held.

endpackage

// file: tcpe_attach_phy_enable.sv
// Type-C attach and orientation decoding into SuperSpeed PHY enables.
// Assumes attach, orientation and polarity inputs are asynchronous pins
// driven by an external configuration-channel detector, and a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module tcpe_attach_phy_enable
  import tcpe_pkg::*;
#(
  parameter int unsigned NUM_ATTACH = TCPE_NUM_ATTACH,
  parameter int unsigned NUM_ORIENT = TCPE_NUM_ORIENT
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_ce,
  input  wire logic [NUM_ATTACH-1:0] i_attach_in,
  input  wire logic [NUM_ORIENT-1:0] i_plug_orientation_in,
  input  wire logic                  i_attach_polarity_sel,
  output logic      [NUM_ATTACH-1:0] o_ss_phy_en,
  output logic      [NUM_ORIENT-1:0] o_phy_a_en,
  output logic      [NUM_ORIENT-1:0] o_phy_b_en
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [NUM_ATTACH-1:0] att_meta;
    logic [NUM_ATTACH-1:0] att_sync;
    logic [NUM_ORIENT-1:0] ori_meta;
    logic [NUM_ORIENT-1:0] ori_sync;
    logic                  pol_meta;
    logic                  pol_sync;
    logic [NUM_ATTACH-1:0] phy_en;
    logic [NUM_ORIENT-1:0] a_en;
    logic [NUM_ORIENT-1:0] b_en;
  } tcpe_state_s;

  tcpe_state_s q;
  tcpe_state_s next_q;
  logic        rst_meta;
  logic        rst_n;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  // Assert at once, release through two flops so no flop sees a runt release.
  // The clock enable gates this pair as well, so a reset is only released
  // while the enable is high; a frozen block therefore stays cleared, which
  // keeps every PHY off until the block really runs.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= TCPE_RST_ASSERTED;
      rst_n    <= TCPE_RST_ASSERTED;
    end else if (i_ce) begin
      rst_meta <= ~TCPE_RST_ASSERTED;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  // Only the second synchroniser stage feeds the decode; the detector pins
  // may change at any time, so the first stage is never looked at.
  // The price is a fixed latency of three enabled edges from a pin change to
  // the outputs, which is negligible against the time a plug takes to settle.
  // Polarity passes the same two stages, so a polarity change and a pin
  // change made together are always decoded as one consistent set.
  always_comb begin
    logic [NUM_ATTACH-1:0] attached;
    logic [NUM_ORIENT-1:0] want_b;
    attached        = '0;
    want_b          = '0;
    next_q          = q;
    next_q.att_meta = i_attach_in;
    next_q.att_sync = q.att_meta;
    next_q.ori_meta = i_plug_orientation_in;
    next_q.ori_sync = q.ori_meta;
    next_q.pol_meta = i_attach_polarity_sel;
    next_q.pol_sync = q.pol_meta;
    // Polarity high inverts the attach meaning; low passes it through.
    attached = q.att_sync ^ {NUM_ATTACH{q.pol_sync}};
    // Polarity high also inverts which level selects PHY B.
    want_b = ~(q.ori_sync ^ {NUM_ORIENT{TCPE_ORIENT_B_RAW ^ q.pol_sync}});
    // A port without attach keeps its PHY powered down.
    next_q.phy_en = attached;
    // Orientation PHYs follow the attach of the same port index only.
    next_q.a_en = attached[NUM_ORIENT-1:0] & ~want_b;
    next_q.b_en = attached[NUM_ORIENT-1:0] & want_b;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Clock enable low freezes everything, including the synchronisers.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  // Outputs come straight from the registered state, so they never glitch.
  assign o_ss_phy_en = q.phy_en;
  assign o_phy_a_en  = q.a_en;
  assign o_phy_b_en  = q.b_en;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Each check except AST_ONE_HOT_ORIENT and AST_FREEZE relates an output to the synchronised levels one enabled edge earlier.
  // The antecedents use the second synchroniser stage, the same levels the decode sees.
  AST_ATTACH_TRACKS: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (o_ss_phy_en == ($past(q.att_sync) ^ {NUM_ATTACH{$past(q.pol_sync)}})))
    else $error("PHY enable does not follow the attach inputs.");

  AST_NO_ATTACH_OFF: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && (q.att_sync[0] == q.pol_sync)) |=> !o_ss_phy_en[0] && !o_phy_a_en[0] && !o_phy_b_en[0])
    else $error("Port 0 PHY powered without an attach.");

  AST_POL_LOW_ATTACH: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_NORMAL && q.att_sync[1]) |=> o_ss_phy_en[1])
    else $error("Attach high at normal polarity did not enable PHY.");

  AST_POL_HIGH_OFF: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && q.att_sync[2]) |=> !o_ss_phy_en[2])
    else $error("Attach high at inverted polarity left PHY on.");

  AST_POL_HIGH_B: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && !q.att_sync[0] && !q.ori_sync[0])
      |=> o_phy_b_en[0] && !o_phy_a_en[0] && o_ss_phy_en[0])
    else $error("Inverted polarity low levels did not select PHY B.");

  AST_ONE_HOT_ORIENT: assert property (@(posedge i_clk) disable iff (!rst_n)
    ##1 ((o_phy_a_en | o_phy_b_en) == o_ss_phy_en[NUM_ORIENT-1:0]) && ((o_phy_a_en & o_phy_b_en) == '0))
    else $error("Orientation PHYs not exclusive or not gated by attach.");

  AST_POL_LOW_ORIENT: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_NORMAL && q.att_sync[1])
      |=> (o_phy_b_en[1] == $past(q.ori_sync[1])) && (o_phy_a_en[1] == !$past(q.ori_sync[1])))
    else $error("Normal polarity orientation picked the wrong PHY.");

  AST_POL_HIGH_A: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && !q.att_sync[1] && q.ori_sync[1])
      |=> o_phy_a_en[1] && !o_phy_b_en[1])
    else $error("Inverted polarity orientation high did not select PHY A.");

  AST_FREEZE: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_ce |=> $stable(o_ss_phy_en) && $stable(o_phy_a_en) && $stable(o_phy_b_en))
    else $error("Outputs moved while the clock enable was low.");

  AST_NO_ATTACH_OFF1: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && (q.att_sync[1] == q.pol_sync)) |=> !o_ss_phy_en[1] && !o_phy_a_en[1] && !o_phy_b_en[1])
    else $error("Port 1 PHY powered without an attach.");

  AST_POL_LOW_DETACH: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_NORMAL && !q.att_sync[0]) |=> !o_ss_phy_en[0])
    else $error("Attach low at normal polarity left PHY on.");

  AST_POL_LOW_ATTACH2: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_NORMAL && q.att_sync[2]) |=> o_ss_phy_en[2])
    else $error("Attach high at normal polarity did not enable port 2 PHY.");

  AST_POL_HIGH_OFF0: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && q.att_sync[0]) |=> !o_ss_phy_en[0] && !o_phy_a_en[0])
    else $error("Attach high at inverted polarity left port 0 PHY on.");

  AST_POL_HIGH_ON: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && !q.att_sync[2]) |=> o_ss_phy_en[2])
    else $error("Attach low at inverted polarity did not enable PHY.");

  AST_POL_HIGH_B1: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && !q.att_sync[1] && !q.ori_sync[1])
      |=> o_phy_b_en[1] && !o_phy_a_en[1] && o_ss_phy_en[1])
    else $error("Inverted polarity low levels did not select PHY B on port 1.");

  AST_POL_LOW_A: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_NORMAL && q.att_sync[0] && !q.ori_sync[0])
      |=> o_phy_a_en[0] && !o_phy_b_en[0])
    else $error("Normal polarity orientation low did not select PHY A.");

  AST_POL_LOW_B: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_NORMAL && q.att_sync[0] && q.ori_sync[0])
      |=> o_phy_b_en[0] && !o_phy_a_en[0])
    else $error("Normal polarity orientation high did not select PHY B.");

  AST_POL_HIGH_A0: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && q.pol_sync == TCPE_POL_INVERTED && !q.att_sync[0] && q.ori_sync[0])
      |=> o_phy_a_en[0] && !o_phy_b_en[0])
    else $error("Inverted polarity orientation high did not select PHY A on port 0.");

  // ---------------------------------------------------------------------------
  // Synchroniser and reset checks
  // ---------------------------------------------------------------------------
  // Each stage must copy the one before it on every enabled edge; a skipped
  // stage would shorten the metastability margin without changing the decode.
  AST_ATTACH_SYNC: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (q.att_sync == $past(q.att_meta)))
    else $error("Attach synchroniser skipped a stage.");

  AST_ORIENT_SYNC: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (q.ori_sync == $past(q.ori_meta)))
    else $error("Orientation synchroniser skipped a stage.");

  AST_POL_SYNC: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (q.pol_sync == $past(q.pol_meta)))
    else $error("Polarity synchroniser skipped a stage.");

  // While the internal reset is held every PHY must stay off, whatever the
  // pins say, so a board in reset draws no SuperSpeed power.
  AST_RESET_CLEARS: assert property (@(posedge i_clk)
    !rst_n |-> (o_ss_phy_en == '0) && (o_phy_a_en == '0) && (o_phy_b_en == '0))
    else $error("Outputs not cleared while reset is held.");

endmodule

`default_nettype wire

// file: tcpe_cc_detector_model.sv
// Model of the external configuration-channel detector that drives the pins.
// Assumes the bench sets the logical attach and orientation to be reported.
`timescale 1ns/1ns
`default_nettype none
module tcpe_cc_detector_model (
  input  wire logic       i_pol,
  input  wire logic       i_legacy,
  input  wire logic [2:0] i_attached,
  input  wire logic [1:0] i_want_b,
  output logic      [2:0] o_attach_pin,
  output logic      [1:0] o_orient_pin
);
  // Pin levels follow the polarity strap, and a legacy board holds attach high.
  always_comb begin
    o_attach_pin = i_legacy ? 3'h7 : (i_attached ^ {3{i_pol}});
    o_orient_pin = i_want_b ^ {2{i_pol}};
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the attach and orientation PHY enable decode.
// Assumes the detector model drives the pins and the bench drives clock, reset and enable.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tcpe_pkg::*;
  logic i_clk = 1'h0, i_arst_n = 1'h0, i_ce = 1'h1, pol = 1'h0, legacy = 1'h0;
  logic [2:0] attached = 3'h0;
  logic [1:0] want_b = 2'h0;
  wire logic [2:0] attach_pin, ss_en;
  wire logic [1:0] orient_pin, a_en, b_en;
  int bad_count = 0, check_count = 0, cycles = 0;
  tcpe_cc_detector_model partner (.i_pol(pol), .i_legacy(legacy), .i_attached(attached),
    .i_want_b(want_b), .o_attach_pin(attach_pin), .o_orient_pin(orient_pin));
  tcpe_attach_phy_enable dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_attach_in(attach_pin),
    .i_plug_orientation_in(orient_pin), .i_attach_polarity_sel(pol), .o_ss_phy_en(ss_en),
    .o_phy_a_en(a_en), .o_phy_b_en(b_en));
  // ---------------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------------------
  // The ceiling is far above the few hundred cycles the scenarios need.
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs change and outputs are sampled 1 ns after an edge, never on it.
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Every attach and orientation pattern under both polarities.
  task automatic t_decode();
    for (int p = 0; p < 2; p++)
      for (int v = 0; v < 32; v++) begin
        pol = p[0];
        attached = v[2:0];
        want_b = v[4:3];
        step(3);
        check(ss_en, attached);
        check({1'h0, a_en}, {1'h0, attached[1:0] & ~want_b});
        check({1'h0, b_en}, {1'h0, attached[1:0] & want_b});
      end
  endtask
  // A held clock enable freezes sampling; the change lands exactly 3 edges after it resumes.
  task automatic t_ce();
    i_ce = 1'h0;
    pol = 1'h0;
    attached = 3'h5;
    step(6);
    check(ss_en, 3'h7);
    i_ce = 1'h1;
    step(2);
    check(ss_en, 3'h7);
    step(1);
    check(ss_en, 3'h5);
  endtask
  // Legacy connectors hold every attach pin high, so at normal polarity every SuperSpeed PHY enable stays on.
  task automatic t_legacy();
    legacy = 1'h1;
    attached = 3'h0;
    step(3);
    check(ss_en, 3'h7);
    legacy = 1'h0;
  endtask
  // A reset in mid-run clears the enables at once; they return five edges after release.
  task automatic t_reset();
    attached = 3'h3;
    step(3);
    i_arst_n = 1'h0;
    #1;
    check(ss_en, 3'h0);
    step(2);
    i_arst_n = 1'h1;
    step(4);
    check(ss_en, 3'h0);
    step(1);
    check(ss_en, 3'h3);
    check({1'h0, b_en}, 3'h3);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_arst_n = 1'h1;
    step(6);
    t_decode();
    t_ce();
    t_legacy();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
